// ===== include/smq_consts.vh
`ifndef SMQ_CONSTS_VH
`define SMQ_CONSTS_VH

// Clock
`define SMQ_CLK_PERIOD_NS 20
`define SMQ_CLK_HZ (1000000000 / `SMQ_CLK_PERIOD_NS)

// Qualification thresholds in Vrms and line cut-off in Vac
`define SMQ_ON_VRMS 8'h46
`define SMQ_OFF_VRMS 8'h32
`define SMQ_LINE_MIN_VAC 8'h50

// Lamp rates in Hz, blink period in seconds
`define SMQ_SLOW_HZ 2
`define SMQ_FAST_HZ 4
`define SMQ_BLINK_S 2
// Half periods in clock cycles at 50 MHz, sized for the divider
`define SMQ_HALF_SLOW 26'hbe_bc20
`define SMQ_HALF_FAST 26'h5f_5e10
`define SMQ_HALF_BLINK 26'h2fa_f080

// Divider register width
`define SMQ_DIV_W 26

// Register byte offsets
`define SMQ_STATUS_OFS 12'h000
`define SMQ_RED_QUAL_OFS 12'h004
`define SMQ_IRQ_STAT_OFS 12'h008
`define SMQ_IRQ_MASK_OFS 12'h00C
`define SMQ_DIV_SLOW_OFS 12'h010
`define SMQ_DIV_FAST_OFS 12'h014
`define SMQ_DIV_BLINK_OFS 12'h018

// Status register fields
`define SMQ_ST_RED_EN 0
`define SMQ_ST_SF1 1
`define SMQ_ST_SF2 2
`define SMQ_ST_PREEMPT 3
`define SMQ_ST_HARNESS 4
`define SMQ_ST_LOW_LINE 5
`define SMQ_ST_MIN_FLASH 6
`define SMQ_ST_DC_LAMP 7
`define SMQ_ST_LINE_LAMP 8
`define SMQ_ST_INVERT 9

// Interrupt bits
`define SMQ_IRQ_W 5
`define SMQ_IRQ_RED_EN 0
`define SMQ_IRQ_PREEMPT 1
`define SMQ_IRQ_HARNESS 2
`define SMQ_IRQ_DC_FAULT 3
`define SMQ_IRQ_LOW_LINE 4
`define SMQ_IRQ_MASK_RST 5'h00

`endif

// ===== hw/smq_qualify.v
`include "smq_consts.vh"
`default_nettype none

// Hysteresis qualifier for one RMS-sampled input
module smq_qualify (
  input wire pclk,
  input wire presetn,
  input wire [7:0] level,
  input wire invert,
  output reg active_r
);

  reg seen_r;
  reg seen_nxt;

  // Above the upper limit sets, below the lower clears, band holds
  always @* begin
    seen_nxt = seen_r;
    if (level > `SMQ_ON_VRMS)
      seen_nxt = 1'b1;
    else if (level < `SMQ_OFF_VRMS)
      seen_nxt = 1'b0;
  end

  // Optional polarity inversion applied after hysteresis
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      seen_r <= seen_nxt;
      active_r <= seen_nxt ^ invert;
    end
  end
endmodule

`default_nettype wire

// ===== hw/smq_divider.v
`include "smq_consts.vh"
`default_nettype none

// Square wave whose half period is a programmable cycle count
module smq_divider (
  input wire pclk,
  input wire presetn,
  input wire [`SMQ_DIV_W-1:0] half,
  output reg wave_r
);

  reg [`SMQ_DIV_W-1:0] cnt_r;
  wire last;

  // Zero is treated as one so the output still toggles
  assign last = (cnt_r + 1'b1 >= half);

  // Counter wraps each half period and flips the wave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {`SMQ_DIV_W{1'b0}};
      wave_r <= 1'b0;
    end else if (last) begin
      cnt_r <= {`SMQ_DIV_W{1'b0}};
      wave_r <= ~wave_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

`default_nettype wire

// ===== hw/smq_top.v
`include "smq_consts.vh"
`default_nettype none

module smq_top #(
  parameter [`SMQ_DIV_W-1:0] HALF_SLOW = `SMQ_HALF_SLOW,
  parameter [`SMQ_DIV_W-1:0] HALF_FAST = `SMQ_HALF_FAST,
  parameter [`SMQ_DIV_W-1:0] HALF_BLINK = `SMQ_HALF_BLINK
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [127:0] red_rms,
  input wire [7:0] red_enable_rms,
  input wire [7:0] preempt_one_rms,
  input wire [7:0] preempt_two_rms,
  input wire preemption_one_invert_switch,
  input wire red_interface_harness,
  input wire [7:0] line_vac,
  input wire low_line,
  input wire min_flash,
  input wire dc_fault_trig,
  input wire monitor_reset,
  input wire [15:0] yellow_active,
  input wire [15:0] green_active,
  output reg [15:0] red_qual_r,
  output reg red_enable_active_r,
  output reg preempt_active_r,
  output reg red_absence_mon_en_r,
  output reg dual_ind_mon_en_r,
  output reg clearance_mon_en_r,
  output reg basic_mode_r,
  output reg [15:0] chan_red_lamp_r,
  output reg [15:0] chan_yellow_lamp_r,
  output reg [15:0] chan_green_lamp_r,
  output reg line_power_lamp,
  output reg dc_supply_fault_lamp,
  output reg red_fail_blink_lamp,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg [1:0] inv_sync_r;
  reg [1:0] harn_sync_r;

  // Two stages for the board switch and the harness sense
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inv_sync_r <= 2'b00;
      harn_sync_r <= 2'b00;
    end else begin
      inv_sync_r <= {inv_sync_r[0], preemption_one_invert_switch};
      harn_sync_r <= {harn_sync_r[0], red_interface_harness};
    end
  end

  wire invert_s = inv_sync_r[1];
  wire harness_s = harn_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Input qualification

  wire [15:0] red_q;
  wire red_en_q;
  wire sf1_q;
  wire sf2_q;

  // One qualifier per red field input
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_red
      smq_qualify u_red (
        .pclk(pclk),
        .presetn(presetn),
        .level(red_rms[gi*8 +: 8]),
        .invert(1'b0),
        .active_r(red_q[gi])
      );
    end
  endgenerate

  smq_qualify u_red_en (
    .pclk(pclk),
    .presetn(presetn),
    .level(red_enable_rms),
    .invert(1'b0),
    .active_r(red_en_q)
  );

  smq_qualify u_sf1 (
    .pclk(pclk),
    .presetn(presetn),
    .level(preempt_one_rms),
    .invert(invert_s),
    .active_r(sf1_q)
  );

  smq_qualify u_sf2 (
    .pclk(pclk),
    .presetn(presetn),
    .level(preempt_two_rms),
    .invert(1'b0),
    .active_r(sf2_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring enables and channel lamps

  wire preempt_any = sf1_q | sf2_q;
  wire red_mon = red_en_q & harness_s;

  // Red monitoring enables need both the enable and the harness; qualified reds and red lamps need only the harness
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_qual_r <= 16'h0000;
      red_enable_active_r <= 1'b0;
      preempt_active_r <= 1'b0;
      red_absence_mon_en_r <= 1'b0;
      dual_ind_mon_en_r <= 1'b0;
      clearance_mon_en_r <= 1'b0;
      basic_mode_r <= 1'b1;
      chan_red_lamp_r <= 16'h0000;
      chan_yellow_lamp_r <= 16'h0000;
      chan_green_lamp_r <= 16'h0000;
    end else begin
      red_qual_r <= harness_s ? red_q : 16'h0000;
      red_enable_active_r <= red_en_q;
      preempt_active_r <= preempt_any;
      red_absence_mon_en_r <= red_mon & ~preempt_any;
      dual_ind_mon_en_r <= red_mon;
      clearance_mon_en_r <= red_mon;
      basic_mode_r <= ~harness_s;
      chan_red_lamp_r <= harness_s ? red_q : 16'h0000;
      chan_yellow_lamp_r <= yellow_active;
      chan_green_lamp_r <= green_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash dividers and front-panel lamps

  reg [`SMQ_DIV_W-1:0] div_slow_r;
  reg [`SMQ_DIV_W-1:0] div_fast_r;
  reg [`SMQ_DIV_W-1:0] div_blink_r;
  wire wave_slow;
  wire wave_fast;
  wire wave_blink;

  smq_divider u_slow (
    .pclk(pclk),
    .presetn(presetn),
    .half(div_slow_r),
    .wave_r(wave_slow)
  );

  smq_divider u_fast (
    .pclk(pclk),
    .presetn(presetn),
    .half(div_fast_r),
    .wave_r(wave_fast)
  );

  smq_divider u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .half(div_blink_r),
    .wave_r(wave_blink)
  );

  reg line_lamp_nxt;
  reg dc_latch_r;

  // Line-power lamp: cut-off, then minimum flash, then brownout, else on
  always @* begin
    if (line_vac < `SMQ_LINE_MIN_VAC)
      line_lamp_nxt = 1'b0;
    else if (min_flash)
      line_lamp_nxt = wave_fast;
    else if (low_line)
      line_lamp_nxt = wave_slow;
    else
      line_lamp_nxt = 1'b1;
  end

  // Latched supply fault; a new trigger beats a reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_latch_r <= 1'b0;
      line_power_lamp <= 1'b0;
      dc_supply_fault_lamp <= 1'b0;
      red_fail_blink_lamp <= 1'b0;
    end else begin
      if (dc_fault_trig)
        dc_latch_r <= 1'b1;
      else if (monitor_reset)
        dc_latch_r <= 1'b0;
      line_power_lamp <= line_lamp_nxt;
      dc_supply_fault_lamp <= dc_latch_r | dc_fault_trig;
      red_fail_blink_lamp <= (~red_en_q | preempt_any) & wave_blink;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events

  reg red_en_d_r;
  reg preempt_d_r;
  reg harness_d_r;
  reg low_line_d_r;
  reg [`SMQ_IRQ_W-1:0] irq_stat_r;
  reg [`SMQ_IRQ_W-1:0] irq_mask_r;
  wire [`SMQ_IRQ_W-1:0] irq_ev;
  wire rd_stat;

  // Changes of qualified enable, preemption and the harness, a rise of low line and a new supply fault become events
  assign irq_ev[`SMQ_IRQ_RED_EN] = red_en_q ^ red_en_d_r;
  assign irq_ev[`SMQ_IRQ_PREEMPT] = preempt_any ^ preempt_d_r;
  assign irq_ev[`SMQ_IRQ_HARNESS] = harness_s ^ harness_d_r;
  assign irq_ev[`SMQ_IRQ_DC_FAULT] = dc_fault_trig & ~dc_latch_r;
  assign irq_ev[`SMQ_IRQ_LOW_LINE] = low_line & ~low_line_d_r;

  assign irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  assign pready = 1'b1;
  assign rd_stat = acc & ~pwrite & (paddr == `SMQ_IRQ_STAT_OFS);

  // Sticky status clears on read; a same-cycle event stays set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_en_d_r <= 1'b0;
      preempt_d_r <= 1'b0;
      harness_d_r <= 1'b0;
      low_line_d_r <= 1'b0;
      irq_stat_r <= {`SMQ_IRQ_W{1'b0}};
    end else begin
      red_en_d_r <= red_en_q;
      preempt_d_r <= preempt_any;
      harness_d_r <= harness_s;
      low_line_d_r <= low_line;
      irq_stat_r <= (rd_stat ? {`SMQ_IRQ_W{1'b0}} : irq_stat_r) | irq_ev;
    end
  end

  // Writable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= `SMQ_IRQ_MASK_RST;
      div_slow_r <= HALF_SLOW;
      div_fast_r <= HALF_FAST;
      div_blink_r <= HALF_BLINK;
    end else if (wr) begin
      case (paddr)
        `SMQ_IRQ_MASK_OFS: irq_mask_r <= pwdata[`SMQ_IRQ_W-1:0];
        `SMQ_DIV_SLOW_OFS: div_slow_r <= pwdata[`SMQ_DIV_W-1:0];
        `SMQ_DIV_FAST_OFS: div_fast_r <= pwdata[`SMQ_DIV_W-1:0];
        `SMQ_DIV_BLINK_OFS: div_blink_r <= pwdata[`SMQ_DIV_W-1:0];
        default: ;
      endcase
    end
  end

  reg [31:0] rdata_nxt;
  reg hit_nxt;

  // Read mux and address decode
  always @* begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (paddr)
      `SMQ_STATUS_OFS: begin
        rdata_nxt[`SMQ_ST_RED_EN] = red_en_q;
        rdata_nxt[`SMQ_ST_SF1] = sf1_q;
        rdata_nxt[`SMQ_ST_SF2] = sf2_q;
        rdata_nxt[`SMQ_ST_PREEMPT] = preempt_any;
        rdata_nxt[`SMQ_ST_HARNESS] = harness_s;
        rdata_nxt[`SMQ_ST_LOW_LINE] = low_line;
        rdata_nxt[`SMQ_ST_MIN_FLASH] = min_flash;
        rdata_nxt[`SMQ_ST_DC_LAMP] = dc_supply_fault_lamp;
        rdata_nxt[`SMQ_ST_LINE_LAMP] = line_power_lamp;
        rdata_nxt[`SMQ_ST_INVERT] = invert_s;
      end
      `SMQ_RED_QUAL_OFS: rdata_nxt[15:0] = red_qual_r;
      `SMQ_IRQ_STAT_OFS: rdata_nxt[`SMQ_IRQ_W-1:0] = irq_stat_r;
      `SMQ_IRQ_MASK_OFS: rdata_nxt[`SMQ_IRQ_W-1:0] = irq_mask_r;
      `SMQ_DIV_SLOW_OFS: rdata_nxt[`SMQ_DIV_W-1:0] = div_slow_r;
      `SMQ_DIV_FAST_OFS: rdata_nxt[`SMQ_DIV_W-1:0] = div_fast_r;
      `SMQ_DIV_BLINK_OFS: rdata_nxt[`SMQ_DIV_W-1:0] = div_blink_r;
      default: hit_nxt = 1'b0;
    endcase
  end

  // Read data and error are registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel & ~penable & ~pwrite) ? rdata_nxt : prdata;
      pslverr <= psel & ~penable & ~hit_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== testbench/smq_top_asserts.sv
`default_nettype none
////////////////////////////////////////////////////////////////
// Checker on the top-level pins of the qualifier and lamps
module smq_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic [7:0] red_enable_rms,
  input wire logic [7:0] line_vac,
  input wire logic low_line,
  input wire logic min_flash,
  input wire logic dc_fault_trig,
  input wire logic [15:0] red_qual_r,
  input wire logic red_enable_active_r,
  input wire logic preempt_active_r,
  input wire logic red_absence_mon_en_r,
  input wire logic dual_ind_mon_en_r,
  input wire logic clearance_mon_en_r,
  input wire logic basic_mode_r,
  input wire logic line_power_lamp,
  input wire logic dc_supply_fault_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Enable level held above the band
  sequence s_en_hi;
    (red_enable_rms > 8'h46) [*2];
  endsequence
  property p_en_hi;
    s_en_hi |=> red_enable_active_r;
  endproperty
  property p_dual;
    dual_ind_mon_en_r == (red_enable_active_r && !basic_mode_r) &&
      clearance_mon_en_r == dual_ind_mon_en_r;
  endproperty
  property p_abs;
    red_absence_mon_en_r == (dual_ind_mon_en_r && !preempt_active_r);
  endproperty
  property p_basic;
    basic_mode_r |-> red_qual_r == 16'h0000;
  endproperty
  property p_off;
    line_vac < 8'h50 |=> !line_power_lamp;
  endproperty
  property p_on;
    line_vac >= 8'h50 && !min_flash && !low_line |=> line_power_lamp;
  endproperty
  property p_dc;
    dc_fault_trig |=> dc_supply_fault_lamp;
  endproperty
  property p_err;
    psel && penable && paddr > 12'h018 |-> pslverr;
  endproperty
  a_en_hi: assert property (p_en_hi) else $error("enable");
  a_dual: assert property (p_dual) else $error("dual");
  a_abs: assert property (p_abs) else $error("absence");
  a_basic: assert property (p_basic) else $error("basic");
  a_off: assert property (p_off) else $error("lamp off");
  a_on: assert property (p_on) else $error("lamp on");
  a_dc: assert property (p_dc) else $error("dc lamp");
  a_err: assert property (p_err) else $error("slverr");
endmodule

bind smq_top smq_top_asserts u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pslverr, .red_enable_rms, .line_vac, .low_line, .min_flash,
  .dc_fault_trig, .red_qual_r, .red_enable_active_r, .preempt_active_r,
  .red_absence_mon_en_r, .dual_ind_mon_en_r, .clearance_mon_en_r,
  .basic_mode_r, .line_power_lamp, .dc_supply_fault_lamp);
`default_nettype wire

// ===== testbench/smq_field.sv
`default_nettype none
////////////////////////////////////////////////////////////////
// Cabinet side: sampled field levels and board pins
module smq_field (
  input wire logic pclk,
  input wire logic [151:0] cmd,
  input wire logic [1:0] pins,
  output logic [127:0] red_rms,
  output logic [7:0] red_enable_rms,
  output logic [7:0] preempt_one_rms,
  output logic [7:0] preempt_two_rms,
  output logic preemption_one_invert_switch,
  output logic red_interface_harness
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet field before the first sample
  initial begin
    red_rms = '0;
    red_enable_rms = 8'h00;
    preempt_one_rms = 8'h00;
    preempt_two_rms = 8'h00;
    {preemption_one_invert_switch, red_interface_harness} = 2'h0;
  end
  // One fresh reading per clock; unplugged reds sit on the terminators
  always @(posedge pclk) begin
    red_rms <= pins[0] ? cmd[127:0] : '0;
    red_enable_rms <= cmd[135:128];
    preempt_one_rms <= cmd[143:136];
    preempt_two_rms <= cmd[151:144];
    {preemption_one_invert_switch, red_interface_harness} <= pins;
  end
endmodule
`default_nettype wire

// ===== testbench/tb_signal_monitor_input_qualify_indicators.sv
`default_nettype none
////////////////////////////////////////////////////////////////
// Self-checking bench for the qualifier and lamp block
module tb_signal_monitor_input_qualify_indicators;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, low_line = 1'b0, min_flash = 1'b0, se;
  logic dc_fault_trig = 1'b0, monitor_reset = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, seed = 32'h0000_436f;
  logic [7:0] line_vac = 8'h78;
  logic [15:0] yellow_active = 16'h0000, green_active = 16'h0000;
  logic [151:0] cmd = '0;
  logic [1:0] pins = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, red_enable_active_r, preempt_active_r;
  logic red_absence_mon_en_r, dual_ind_mon_en_r, clearance_mon_en_r;
  logic basic_mode_r, line_power_lamp, dc_supply_fault_lamp;
  logic red_fail_blink_lamp, preemption_one_invert_switch;
  logic red_interface_harness;
  logic [127:0] red_rms;
  logic [7:0] red_enable_rms, preempt_one_rms, preempt_two_rms;
  logic [15:0] red_qual_r, chan_red_lamp_r, chan_yellow_lamp_r;
  logic [15:0] chan_green_lamp_r;
  logic [5:0] flags;
  logic [1:0] lamps;
  int err_count = 0, checked = 0, cyc = 0, st[19];

  assign flags = {red_enable_active_r, preempt_active_r,
    red_absence_mon_en_r, dual_ind_mon_en_r, clearance_mon_en_r,
    basic_mode_r};
  assign lamps = {red_fail_blink_lamp, line_power_lamp};

  always #10 pclk = ~pclk;

  // Run limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("[ERR] %0t run limit reached", $time);
      wrap_up();
    end
  end

  smq_field field (.pclk, .cmd, .pins, .red_rms, .red_enable_rms,
    .preempt_one_rms, .preempt_two_rms, .preemption_one_invert_switch,
    .red_interface_harness);

  smq_top #(.HALF_SLOW(26'h0004), .HALF_FAST(26'h0002),
    .HALF_BLINK(26'h0008)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .red_rms,
    .red_enable_rms, .preempt_one_rms, .preempt_two_rms,
    .preemption_one_invert_switch, .red_interface_harness, .line_vac,
    .low_line, .min_flash, .dc_fault_trig, .monitor_reset,
    .yellow_active, .green_active, .red_qual_r, .red_enable_active_r,
    .preempt_active_r, .red_absence_mon_en_r, .dual_ind_mon_en_r,
    .clearance_mon_en_r, .basic_mode_r, .chan_red_lamp_r,
    .chan_yellow_lamp_r, .chan_green_lamp_r, .line_power_lamp,
    .dc_supply_fault_lamp, .red_fail_blink_lamp, .irq);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Count lamp changes; h is the half period, 0 for steady
  task automatic togs(input int b, input int n, input int h);
    int c;
    logic p;
    c = 0;
    p = lamps[b];
    repeat (n) begin
      @(posedge pclk);
      if (lamps[b] !== p) c++;
      p = lamps[b];
    end
    chk(h ? c >= n / h - 1 && c <= n / h + 1 : c == 0, 1);
  endtask

  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    logic [31:0] k;
    logic [7:0] v;
    logic [15:0] q;
    logic p, en;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Mask reset value and an unmapped read
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk(rd, 0);
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk({se, rd}, 33'h1_0000_0000);
    // Random field levels against the hysteresis model
    repeat (40) begin
      k = xs();
      pins <= k[1:0];
      yellow_active <= k[17:2];
      green_active <= k[31:16];
      for (int i = 0; i < 19; i++) begin
        v = xs() >> 24;
        cmd[8*i +: 8] <= v;
        st[i] = v > 70 ? 1 : v < 50 ? 0 : st[i];
        if (i < 16 && !k[0]) st[i] = 0;
      end
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 16; i++) q[i] = st[i] != 0 && k[0];
      en = st[16] != 0;
      p = (st[17] != 0) ^ k[1] || st[18] != 0;
      chk({red_qual_r, chan_red_lamp_r}, {q, q});
      chk({chan_yellow_lamp_r, chan_green_lamp_r}, k[17:2] << 16 | k[31:16]);
      chk(flags, {en, p, en & k[0] & !p, en & k[0], en & k[0], !k[0]});
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd, q);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, {k[1], 4'h8, k[0], p, st[18] != 0, (st[17] != 0) ^ k[1], en});
    end
    // Undervoltage beats every flash request
    cmd <= '0;
    pins <= 2'h1;
    line_vac <= 8'h4f;
    low_line <= 1'b1;
    min_flash <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(line_power_lamp, 0);
    togs(0, 24, 0);
    // Minimum flash rate, then low-line rate
    line_vac <= 8'h50;
    k = 2 + xs() % 4;
    apb(1'b1, 12'h014, k);
    repeat (8) @(posedge pclk);
    togs(0, 48, k);
    min_flash <= 1'b0;
    k = 3 + xs() % 4;
    apb(1'b1, 12'h010, k);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, k);
    repeat (8) @(posedge pclk);
    togs(0, 48, k);
    low_line <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(line_power_lamp, 1);
    togs(0, 24, 0);
    // Red-fail lamp blinks until the enable comes up
    togs(1, 48, 8);
    cmd[135:128] <= 8'h50;
    repeat (8) @(posedge pclk);
    togs(1, 24, 0);
    chk(red_fail_blink_lamp, 0);
    // Supply fault lamp and its interrupt
    apb(1'b1, 12'h00c, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    // Enable rise, harness change and low-line rise were all latched
    chk(rd & 32'hffff_fffd, 32'h0000_0015);
    dc_fault_trig <= 1'b1;
    @(posedge pclk);
    dc_fault_trig <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({dc_supply_fault_lamp, irq}, 2'h2);
    apb(1'b1, 12'h00c, 32'h0000_0008);
    chk(irq, 1);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk({rd, irq}, 33'h0_0000_0010);
    monitor_reset <= 1'b1;
    @(posedge pclk);
    monitor_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(dc_supply_fault_lamp, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
